// ### design/timer_compare_regs.svh
`ifndef TIMER_COMPARE_REGS_SVH
`define TIMER_COMPARE_REGS_SVH

`define CNT_WIDTH        8
`define CNT_BOTTOM       8'h00
`define CNT_MAX          8'hFF
`define STATE_RESET      1'b0
`define WGM_NORMAL       3'h0
`define WGM_CLEAR_MATCH  3'h2
`define COM_NONE         2'h0
`define COM_TOGGLE       2'h1
`define COM_CLEAR        2'h2
`define COM_SET          2'h3
`define PRESCALE_SEL_W   3
`define PRESCALE_MAX     1024

`endif

// ### design/timer_compare_pkg.sv
package timer_compare_pkg;
   typedef logic [7:0] count_type;
   typedef logic [1:0] com_mode_type;
   typedef logic [2:0] wgm_type;
   typedef enum logic [2:0] {
      clock_stopped,
      clock_div1,
      clock_div8,
      clock_div64,
      clock_div256,
      clock_div1024
   } clock_select_type;
endpackage

// ### design/compare_channel_if.sv
`timescale 1ns/1ps
interface compare_channel_if;
   import timer_compare_pkg::*;
   com_mode_type mode;
   logic         match;
   logic         force_strobe;
   logic         non_pwm;
   logic         state;
   modport owner (output mode, output match, output force_strobe, output non_pwm, input state);
   modport channel (input mode, input match, input force_strobe, input non_pwm, output state);
endinterface

// ### design/timer_prescaler.sv
`timescale 1ns/1ps
`include "timer_compare_regs.svh"
module timer_prescaler
#(
   parameter int DIV_MAX = `PRESCALE_MAX
) (
   input  wire logic                                clk_in,
   input  wire logic                                rst_n_in,
   input  wire timer_compare_pkg::clock_select_type sel_in,
   output logic                                     tick_out
);
   import timer_compare_pkg::*;

   logic [$clog2(DIV_MAX)-1:0] div_q;
   logic                       tap;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end

   // tick one cycle in N: all low bits of the free divider are ones
   always_comb begin
      case (sel_in)
         clock_div1:    tap = 1'b1;
         clock_div8:    tap = &div_q[2:0];
         clock_div64:   tap = &div_q[5:0];
         clock_div256:  tap = &div_q[7:0];
         clock_div1024: tap = &div_q[9:0];
         default:       tap = 1'b0;
      endcase
   end

   assign tick_out = tap;
endmodule

// ### design/compare_output_channel.sv
`timescale 1ns/1ps
`include "timer_compare_regs.svh"
module compare_output_channel
   import timer_compare_pkg::*;
(
   input  wire logic   clk_in,
   input  wire logic   rst_n_in,
   compare_channel_if.channel ch
);
   logic state_q;
   logic state_d;

   always_comb begin
      state_d = state_q;
      if (ch.match || (ch.force_strobe && ch.non_pwm)) begin
         case (ch.mode)
            `COM_TOGGLE: state_d = ~state_q;
            `COM_CLEAR:  state_d = 1'b0;
            `COM_SET:    state_d = 1'b1;
            default:     state_d = state_q;
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_q <= `STATE_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   assign ch.state = state_q;
endmodule

// ### design/timer_compare_output_ctc.sv
`timescale 1ns/1ps
`include "timer_compare_regs.svh"
// Behaviour
// RL1 - reset clears both compare output states
// RL2 - nonzero mode field overrides port value
// RL3 - pin drives only when direction selects output
// RL4 - override ignores waveform mode
// RL5 - state settable before pin enabled
// RL6 - mode zero leaves state untouched
// RL7 - new mode acts at next match; force immediate
// RL8 - counting depends only on waveform mode
// RL9 - mode selects set, clear or toggle
// RL10 - normal mode increments, wraps FF to 00
// RL11 - overflow flag set when counter becomes zero; code sets it only on FF to 00 wrap, not on clear or write
// RL12 - interrupt acknowledge clears overflow flag
// RL13 - counter writable anytime in normal mode
// RL14 - compare flags raised in normal mode
// RL15 - clear-on-match clears counter at compare A
// RL16 - compare flag A set at top
// RL17 - unbuffered compare A, missed top wraps
// RL18 - channel A mode one toggles on match
// RL19 - prescale factors 1, 8, 64, 256, 1024
// RL20 - overflow flag set on wrap in clear-on-match
// RL21 - writing one clears a compare flag
// RL22 - counter write beats clear or count
// RL23 - counter write blocks next tick's matches
// RL24 - force updates state, no flag, no clear
// RL25 - counting advances only on prescaled tick
module timer_compare_output_ctc
   import timer_compare_pkg::*;
(
   input  wire logic                           clk_in,
   input  wire logic                           rst_n_in,
   input  wire timer_compare_pkg::clock_select_type clock_select_in,
   input  wire timer_compare_pkg::wgm_type     waveform_mode_select_in,
   input  wire timer_compare_pkg::com_mode_type compare_output_mode_a_in,
   input  wire timer_compare_pkg::com_mode_type compare_output_mode_b_in,
   input  wire logic                           force_compare_strobe_a_in,
   input  wire logic                           force_compare_strobe_b_in,
   input  wire timer_compare_pkg::count_type   compare_value_a_in,
   input  wire timer_compare_pkg::count_type   compare_value_b_in,
   input  wire logic                           counter_write_in,
   input  wire timer_compare_pkg::count_type   counter_write_data_in,
   input  wire logic                           compare_flag_a_clear_in,
   input  wire logic                           compare_flag_b_clear_in,
   input  wire logic                           overflow_flag_clear_in,
   input  wire logic                           compare_a_int_ack_in,
   input  wire logic                           compare_b_int_ack_in,
   input  wire logic                           overflow_int_ack_in,
   input  wire logic                           port_value_a_in,
   input  wire logic                           port_value_b_in,
   input  wire logic                           port_dir_out_a_in,
   input  wire logic                           port_dir_out_b_in,
   output timer_compare_pkg::count_type        counter_value_out,
   output logic                                compare_flag_a_out,
   output logic                                compare_flag_b_out,
   output logic                                overflow_flag_out,
   output logic                                compare_output_state_a_out,
   output logic                                compare_output_state_b_out,
   output logic                                pin_a_out,
   output logic                                pin_a_oe_n_out,
   output logic                                pin_b_out,
   output logic                                pin_b_oe_n_out
);
   import timer_compare_pkg::*;

   count_type counter_value_q;
   count_type counter_value_d;
   logic      block_match_q;
   logic      compare_flag_a_q;
   logic      compare_flag_b_q;
   logic      overflow_flag_q;
   logic      pin_a_q;
   logic      pin_a_oe_n_q;
   logic      pin_b_q;
   logic      pin_b_oe_n_q;
   logic      tick;
   logic      non_pwm;
   logic      ctc_mode;
   logic      match_a;
   logic      match_b;
   logic      wrap;

   compare_channel_if chan_a ();
   compare_channel_if chan_b ();

   timer_prescaler #(
      .DIV_MAX (`PRESCALE_MAX)
   ) prescaler (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .sel_in   (clock_select_in),
      .tick_out (tick)
   ); // RL19

   assign ctc_mode = (waveform_mode_select_in == `WGM_CLEAR_MATCH);
   assign non_pwm  = (waveform_mode_select_in == `WGM_NORMAL) || ctc_mode;

   // matches are evaluated only on a tick, and not on the tick after a counter write
   assign match_a = tick && !block_match_q
                    && (counter_value_q == compare_value_a_in); // RL25 RL23
   assign match_b = tick && !block_match_q
                    && (counter_value_q == compare_value_b_in); // RL25 RL23

   // compare A is live, so a value below the count is simply passed and the count wraps
   assign wrap = tick && (counter_value_q == `CNT_MAX) && !(ctc_mode && match_a); // RL17

   always_comb begin
      counter_value_d = counter_value_q;
      if (counter_write_in) begin
         counter_value_d = counter_write_data_in; // RL22 RL13
      end else if (tick) begin
         if (ctc_mode && match_a) begin
            counter_value_d = `CNT_BOTTOM; // RL15
         end else begin
            counter_value_d = counter_value_q + 8'h01; // RL10 RL8
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         counter_value_q <= `CNT_BOTTOM;
      end else begin
         counter_value_q <= counter_value_d;
      end
   end

   // the block persists until the next tick has been consumed, so a stopped timer keeps it
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         block_match_q <= 1'b0;
      end else if (counter_write_in) begin
         block_match_q <= 1'b1; // RL23
      end else if (tick) begin
         block_match_q <= 1'b0;
      end
   end

   // flags: hardware set wins over a clear in the same cycle
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         compare_flag_a_q <= 1'b0;
         compare_flag_b_q <= 1'b0;
      end else begin
         if (match_a) begin
            compare_flag_a_q <= 1'b1; // RL14 RL16
         end else if (compare_flag_a_clear_in || compare_a_int_ack_in) begin
            compare_flag_a_q <= 1'b0; // RL21
         end
         if (match_b) begin
            compare_flag_b_q <= 1'b1; // RL14
         end else if (compare_flag_b_clear_in || compare_b_int_ack_in) begin
            compare_flag_b_q <= 1'b0; // RL21
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         overflow_flag_q <= 1'b0;
      end else if (wrap && !counter_write_in) begin
         overflow_flag_q <= 1'b1; // RL11 RL20
      end else if (overflow_int_ack_in || overflow_flag_clear_in) begin
         overflow_flag_q <= 1'b0; // RL12
      end
   end

   // mode is read live at each match, so a new value acts on the next match
   assign chan_a.mode         = compare_output_mode_a_in; // RL7
   assign chan_a.match        = match_a; // RL9 RL18 RL6
   assign chan_a.force_strobe = force_compare_strobe_a_in; // RL24
   assign chan_a.non_pwm      = non_pwm;
   assign chan_b.mode         = compare_output_mode_b_in;
   assign chan_b.match        = match_b; // RL9 RL6
   assign chan_b.force_strobe = force_compare_strobe_b_in; // RL24
   assign chan_b.non_pwm      = non_pwm;

   compare_output_channel channel_a (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .ch       (chan_a)
   ); // RL1 RL5
   compare_output_channel channel_b (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .ch       (chan_b)
   ); // RL1 RL5

   // pin mux sees the state one cycle late, traded for registered outputs
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pin_a_q      <= 1'b0;
         pin_b_q      <= 1'b0;
         pin_a_oe_n_q <= 1'b1;
         pin_b_oe_n_q <= 1'b1;
      end else begin
         pin_a_q      <= (|compare_output_mode_a_in) ? chan_a.state : port_value_a_in; // RL2 RL4
         pin_b_q      <= (|compare_output_mode_b_in) ? chan_b.state : port_value_b_in; // RL2 RL4
         pin_a_oe_n_q <= !port_dir_out_a_in; // RL3
         pin_b_oe_n_q <= !port_dir_out_b_in; // RL3
      end
   end

   assign counter_value_out          = counter_value_q;
   assign compare_flag_a_out         = compare_flag_a_q;
   assign compare_flag_b_out         = compare_flag_b_q;
   assign overflow_flag_out          = overflow_flag_q;
   assign compare_output_state_a_out = chan_a.state;
   assign compare_output_state_b_out = chan_b.state;
   assign pin_a_out                  = pin_a_q;
   assign pin_a_oe_n_out             = pin_a_oe_n_q;
   assign pin_b_out                  = pin_b_q;
   assign pin_b_oe_n_out             = pin_b_oe_n_q;
endmodule

// ### testbench/timer_compare_output_ctc_chk.sv
`timescale 1ns/1ps
module timer_compare_output_ctc_chk (
   input wire logic                              clk_in,
   input wire logic                              rst_n_in,
   input wire timer_compare_pkg::clock_select_type clock_select_in,
   input wire timer_compare_pkg::wgm_type        waveform_mode_select_in,
   input wire timer_compare_pkg::com_mode_type   compare_output_mode_a_in,
   input wire timer_compare_pkg::count_type      compare_value_a_in,
   input wire logic                              counter_write_in,
   input wire logic                              port_value_a_in,
   input wire logic                              port_dir_out_a_in,
   input wire timer_compare_pkg::count_type      counter_value_out,
   input wire logic                              compare_flag_a_out,
   input wire logic                              overflow_flag_out,
   input wire logic                              compare_output_state_a_out,
   input wire logic                              pin_a_out,
   input wire logic                              pin_a_oe_n_out
);
   import timer_compare_pkg::*;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // two settled div1 cycles without a write, so the earlier tick has cleared the match block
   sequence tick_s;
      clock_select_in == clock_div1 && $past(clock_select_in) == clock_div1
      && $past(rst_n_in) && !counter_write_in && !$past(counter_write_in);
   endsequence
   sequence match_a_s;
      tick_s ##0 counter_value_out == compare_value_a_in;
   endsequence
   reset_clears_a: assert property (disable iff (1'b0) !rst_n_in |=> !compare_output_state_a_out)
      else $error("state not cleared by reset");
   pin_source_a: assert property ($past(rst_n_in) |-> pin_a_out == ($past(compare_output_mode_a_in)
      != 2'h0 ? $past(compare_output_state_a_out) : $past(port_value_a_in)))
      else $error("pin source wrong");
   oe_follows_a: assert property ($past(rst_n_in) |-> pin_a_oe_n_out == !$past(port_dir_out_a_in))
      else $error("pin enable does not follow direction");
   none_holds_a: assert property (compare_output_mode_a_in == 2'h0 |=> $stable(compare_output_state_a_out))
      else $error("state moved with mode zero");
   normal_count_a: assert property (tick_s ##0 waveform_mode_select_in == 3'h0 |=>
      counter_value_out == count_type'($past(counter_value_out) + 8'h01))
      else $error("normal count step wrong");
   ctc_clear_a: assert property (match_a_s ##0 waveform_mode_select_in == 3'h2 |=> counter_value_out == 8'h00)
      else $error("counter not cleared at top");
   flag_a_set_a: assert property (match_a_s |=> compare_flag_a_out)
      else $error("compare flag not set");
   overflow_set_a: assert property (tick_s ##0 counter_value_out == 8'hFF ##0
      !(waveform_mode_select_in == 3'h2 && compare_value_a_in == 8'hFF) |=> overflow_flag_out)
      else $error("overflow flag not set");
   toggle_match_a: assert property (match_a_s ##0 (waveform_mode_select_in == 3'h2 &&
      compare_output_mode_a_in == 2'h1) |=> $changed(compare_output_state_a_out))
      else $error("state not toggled");
endmodule
bind timer_compare_output_ctc timer_compare_output_ctc_chk timer_compare_output_ctc_chk_inst (
   .clk_in(clk_in), .rst_n_in(rst_n_in), .clock_select_in(clock_select_in),
   .waveform_mode_select_in(waveform_mode_select_in),
   .compare_output_mode_a_in(compare_output_mode_a_in), .compare_value_a_in(compare_value_a_in),
   .counter_write_in(counter_write_in), .port_value_a_in(port_value_a_in),
   .port_dir_out_a_in(port_dir_out_a_in), .counter_value_out(counter_value_out),
   .compare_flag_a_out(compare_flag_a_out), .overflow_flag_out(overflow_flag_out),
   .compare_output_state_a_out(compare_output_state_a_out), .pin_a_out(pin_a_out),
   .pin_a_oe_n_out(pin_a_oe_n_out));

// ### testbench/pin_load_model.sv
`timescale 1ns/1ps
module pin_load_model (
   input  wire logic pin_in,
   input  wire logic pin_oe_n_in,
   output logic      level_out
);
   // undriven line shows the inverse so a stale value never passes for a drive
   assign level_out = pin_oe_n_in ? ~pin_in : pin_in;
endmodule

// ### testbench/timer_compare_output_ctc_tb_top.sv
`timescale 1ns/1ps
`define CHECK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
   $display("ERROR %0t got %0h exp %0h", $time, g, e); end end
module timer_compare_output_ctc_tb_top;
   import timer_compare_pkg::*;
   logic             clk = 1'b0, rst_n = 1'b0, force_a = 1'b0, force_b = 1'b0, cw = 1'b0;
   logic             fclr_a = 1'b0, fclr_b = 1'b0, ack = 1'b0, pv_a = 1'b0, dir_a = 1'b0;
   logic             flag_a, flag_b, ovf, st_a, st_b, pin_a, oe_a, level_a, pin_b, oe_b;
   clock_select_type csel = clock_stopped;
   wgm_type          wgm = 3'h0;
   com_mode_type     mode_a = 2'h0, mode_b = 2'h0;
   count_type        cmp_a = 8'h00, cmp_b = 8'h00, cw_data = 8'h00, cnt;
   int               error_cnt = 0, comparisons = 0;
   always #2 clk = ~clk;
   timer_compare_output_ctc timer_compare_output_ctc_inst (.clk_in(clk), .rst_n_in(rst_n),
      .clock_select_in(csel), .waveform_mode_select_in(wgm), .compare_output_mode_a_in(mode_a),
      .compare_output_mode_b_in(mode_b), .force_compare_strobe_a_in(force_a),
      .force_compare_strobe_b_in(force_b), .compare_value_a_in(cmp_a), .compare_value_b_in(cmp_b),
      .counter_write_in(cw), .counter_write_data_in(cw_data), .compare_flag_a_clear_in(fclr_a),
      .compare_flag_b_clear_in(fclr_b), .overflow_flag_clear_in(1'b0), .compare_a_int_ack_in(1'b0),
      .compare_b_int_ack_in(1'b0), .overflow_int_ack_in(ack), .port_value_a_in(pv_a),
      .port_value_b_in(pv_a), .port_dir_out_a_in(dir_a), .port_dir_out_b_in(dir_a),
      .counter_value_out(cnt), .compare_flag_a_out(flag_a), .compare_flag_b_out(flag_b),
      .overflow_flag_out(ovf), .compare_output_state_a_out(st_a), .compare_output_state_b_out(st_b),
      .pin_a_out(pin_a), .pin_a_oe_n_out(oe_a), .pin_b_out(pin_b), .pin_b_oe_n_out(oe_b));
   pin_load_model pin_load_model_inst (.pin_in(pin_a), .pin_oe_n_in(oe_a), .level_out(level_a));
   task automatic stop_test();
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic cyc(int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wait_cnt(count_type v);
      int i;
      for (i = 0; i < 600 && cnt !== v; i++) cyc(1);
      if (i == 600) begin
         error_cnt++;
         stop_test();
      end
   endtask
   task automatic load(count_type v);
      cw_data = v;
      cw = 1'b1;
      cyc(1);
      cw = 1'b0;
   endtask
   task automatic t_normal();
      cmp_b = 8'h80;
      fclr_b = 1'b1;
      load(8'hFD);
      fclr_b = 1'b0;
      `CHECK({cnt, flag_b}, 9'h1FA)
      cyc(3);
      `CHECK({cnt, ovf}, 9'h001)
      ack = 1'b1;
      cyc(1);
      ack = 1'b0;
      `CHECK(ovf, 1'b0)
      wait_cnt(8'h81);
      `CHECK(flag_b, 1'b1)
      fclr_b = 1'b1;
      cyc(1);
      fclr_b = 1'b0;
      `CHECK(flag_b, 1'b0)
   endtask
   task automatic t_block();
      cmp_a = 8'h50;
      fclr_a = 1'b1;
      cyc(1);
      fclr_a = 1'b0;
      load(8'h50);
      cyc(4);
      `CHECK({cnt, flag_a}, 9'h0A8)
      csel = clock_stopped;
      cmp_a = 8'h60;
      load(8'h60);
      cyc(2);
      csel = clock_div1;
      cyc(2);
      `CHECK({cnt, flag_a}, 9'h0C4)
   endtask
   task automatic t_force();
      com_mode_type m[5] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h0};
      logic e[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
      csel = clock_stopped;
      fclr_a = 1'b1;
      cyc(2);
      fclr_a = 1'b0;
      foreach (m[i]) begin
         {mode_a, mode_b, force_a, force_b} = {m[i], m[i], 2'b11};
         cyc(1);
         {force_a, force_b} = 2'b00;
         `CHECK({st_a, st_b, flag_a, cnt}, {e[i], e[i], 1'b0, 8'h62})
      end
   endtask
   task automatic t_pin();
      {pv_a, dir_a} = 2'b11;
      cyc(2);
      `CHECK({pin_a, oe_a, level_a, pin_b, oe_b}, 5'b10110)
      {mode_a, wgm} = {2'h3, 3'h2};
      cyc(2);
      `CHECK({level_a, st_a, pin_b}, 3'b001)
      dir_a = 1'b0;
      cyc(2);
      `CHECK({oe_a, oe_b}, 2'b11)
   endtask
   task automatic t_ctc();
      int i;
      int n;
      logic s;
      csel = clock_div1;
      cmp_a = 8'h10;
      mode_a = 2'h1;
      load(8'hF0);
      wait_cnt(8'h00);
      `CHECK({ovf, flag_a}, 2'b10)
      wait_cnt(8'h10);
      cyc(1);
      `CHECK({cnt, flag_a}, 9'h001)
      cmp_a = 8'h03;
      s = st_a;
      for (i = 0; i < 300 && st_a === s; i++) cyc(1);
      if (i == 300) begin
         error_cnt++;
         stop_test();
      end
      s = st_a;
      for (n = 0; n < 20 && st_a === s; n++) cyc(1);
      `CHECK(n, 4)
   endtask
   // the first gap after a select change is partial, so the second one is measured
   task automatic t_prescale();
      clock_select_type sel[4] = '{clock_div8, clock_div64, clock_div256, clock_div1024};
      int f[4] = '{8, 64, 256, 1024};
      int n;
      count_type c;
      foreach (sel[k]) begin
         csel = sel[k];
         for (int j = 0; j < 2; j++) begin
            c = cnt;
            for (n = 0; n < 2100 && cnt === c; n++) cyc(1);
         end
         `CHECK(n, f[k])
      end
   endtask
   initial begin
      cyc(20);
      rst_n = 1'b1;
      cyc(2);
      `CHECK({cnt, flag_a, flag_b, ovf, st_a, st_b, oe_a}, 14'h0001)
      csel = clock_div1;
      cyc(3);
      t_normal();
      t_block();
      t_force();
      t_pin();
      t_ctc();
      t_prescale();
      stop_test();
   end
endmodule
